// ---- src/flash_host_pkg.sv ----
// flash_host_pkg: constants, opcodes, timing counts and carrier types for the flash host
// assumes a 250 MHz system clock and a parallel nor flash with x16/x8 address modes
package flash_host_pkg;

  // clock and bus-cycle timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int T_TICK_NS = 10;
  localparam int TICK_CYC = (T_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TICK_NS = TICK_CYC * CLK_PERIOD_NS;
  localparam int DIV_W = $clog2(TICK_CYC);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(TICK_CYC - 1);
  localparam int T_SETUP_NS = 10;
  localparam int T_WE_LOW_NS = 40;
  localparam int T_HOLD_NS = 20;
  localparam int T_ACCESS_NS = 100;
  localparam logic [3:0] SETUP_TICKS = 4'((T_SETUP_NS + TICK_NS - 1) / TICK_NS);
  localparam logic [3:0] WE_LOW_TICKS = 4'((T_WE_LOW_NS + TICK_NS - 1) / TICK_NS);
  localparam logic [3:0] HOLD_TICKS = 4'((T_HOLD_NS + TICK_NS - 1) / TICK_NS);
  localparam logic [3:0] ACCESS_TICKS = 4'((T_ACCESS_NS + TICK_NS - 1) / TICK_NS);

  // write buffer geometry
  localparam int BUF_DEPTH_DEF = 32;
  localparam logic [4:0] WORD_COUNT_MAX = 5'h0F;
  localparam logic [5:0] BUF_FIRST_STEP = 6'h04;
  localparam logic [5:0] BUF_LAST_STEP_WORD = 6'h13;

  // command addresses, word mode and byte mode
  localparam logic [23:0] A_WORD_UNLOCK1 = 24'h00_0555;
  localparam logic [23:0] A_WORD_UNLOCK2 = 24'h00_02AA;
  localparam logic [23:0] A_WORD_QUERY = 24'h00_0055;
  localparam logic [23:0] A_BYTE_UNLOCK1 = 24'h00_0AAA;
  localparam logic [23:0] A_BYTE_UNLOCK2 = 24'h00_0555;
  localparam logic [23:0] A_BYTE_QUERY = 24'h00_00AA;

  // command data codes
  localparam logic [7:0] OP_UNLOCK1 = 8'hAA;
  localparam logic [7:0] OP_UNLOCK2 = 8'h55;
  localparam logic [7:0] OP_RESET = 8'hF0;
  localparam logic [7:0] OP_IDENT = 8'h90;
  localparam logic [7:0] OP_SECURE = 8'h88;
  localparam logic [7:0] OP_EXIT = 8'h00;
  localparam logic [7:0] OP_PROGRAM = 8'hA0;
  localparam logic [7:0] OP_BUF_LOAD = 8'h25;
  localparam logic [7:0] OP_BUF_COMMIT = 8'h29;
  localparam logic [7:0] OP_BYPASS = 8'h20;
  localparam logic [7:0] OP_ERASE_SETUP = 8'h80;
  localparam logic [7:0] OP_CHIP_ERASE = 8'h10;
  localparam logic [7:0] OP_SECTOR_ERASE = 8'h30;
  localparam logic [7:0] OP_SUSPEND = 8'hB0;
  localparam logic [7:0] OP_RESUME = 8'h30;
  localparam logic [7:0] OP_QUERY = 8'h98;

  typedef enum logic [4:0] {
    C_READ, C_RESET, C_IDENT, C_SEC_ENTER, C_SEC_EXIT, C_PROGRAM, C_BUF_LOAD,
    C_BUF_COMMIT, C_BUF_ABORT, C_BYP_ENTER, C_BYP_PROG, C_BYP_EXIT,
    C_CHIP_ERASE, C_SECT_ERASE, C_SUSPEND, C_RESUME, C_QUERY
  } cmd_t;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_SETUP = 5'h02,
    ST_STROBE = 5'h04,
    ST_HOLD = 5'h08,
    ST_FINISH = 5'h10
  } st_t;

  typedef struct packed {
    cmd_t cmd;
    logic [23:0] addr;
    logic [15:0] data;
    logic [4:0] count;
  } req_t;

  typedef struct packed {
    logic [22:0] addr;
    logic addr_lsb;
    logic [15:0] dq;
    logic dq_oe;
    logic ce_n;
    logic we_n;
    logic oe_n;
    logic byte_n;
  } pin_t;

  typedef struct packed {
    logic ident;
    logic secure;
    logic bypass;
    logic erasing;
    logic suspended;
  } mode_t;

  typedef struct packed {
    logic [23:0] addr;
    logic [15:0] data;
    logic rd;
    logic last;
  } step_t;

  typedef struct packed {
    st_t st;
    logic [5:0] step;
    logic [3:0] cnt;
    logic [DIV_W-1:0] div;
    req_t req;
    logic bm;
    pin_t pins;
    mode_t mode;
    logic [15:0] rdata;
    logic ready;
    logic done;
    logic refused;
  } state_t;

endpackage

// ---- src/flash_buf_mem.sv ----
// flash_buf_mem: write-buffer image that the host loads before a buffer program
// assumes one clock; read data appear one cycle after the read address
`timescale 1ns/1ps
`default_nettype none
module flash_buf_mem #(
  parameter int DATA_W = 16,
  parameter int DEPTH = 32,
  parameter int AW = $clog2(DEPTH)
) (
  // clock
  input wire logic clk_i,
  // write side
  input wire logic we_i,
  input wire logic [AW-1:0] waddr_i,
  input wire logic [DATA_W-1:0] wdata_i,
  // read side
  input wire logic [AW-1:0] raddr_i,
  output var logic [DATA_W-1:0] rdata_o
);
  logic [DATA_W-1:0] mem [DEPTH];

  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
    rdata_o <= mem[raddr_i];
  end
endmodule // flash_buf_mem
`default_nettype wire

// ---- src/flash_host_ctrl.sv ----
// flash_host_ctrl: host controller that writes command sequences to a parallel nor flash
// assumes flash pins wired to the device, DQ_I synchronous to CLK_I, one request at a time
`timescale 1ns/1ps
`default_nettype none
module flash_host_ctrl
  import flash_host_pkg::*;
#(
  parameter int BUF_DEPTH = BUF_DEPTH_DEF,
  parameter int AW = $clog2(BUF_DEPTH)
) (
  // clock and reset
  input wire logic CLK_I,
  input wire logic RSTN_I,
  // command request
  input wire logic CMD_VALID_I,
  input wire req_t CMD_I,
  input wire logic BYTE_MODE_I,
  output var logic CMD_READY_O,
  // write buffer load
  input wire logic LOAD_WE_I,
  input wire logic [AW-1:0] LOAD_IDX_I,
  input wire logic [15:0] LOAD_DATA_I,
  // answer
  output var logic DONE_O,
  output var logic REFUSED_O,
  output var logic [15:0] RDATA_O,
  output var mode_t MODE_O,
  // flash pins
  output var pin_t FLASH_O,
  input wire logic [15:0] DQ_I
);

  state_t r_reg;
  state_t r_next;
  step_t cur;
  logic tick;
  logic reject;
  logic unl_cmd;
  logic code_only;
  logic [15:0] mem_rdata;
  logic [AW-1:0] mem_raddr;

  // one bus cycle of a sequence, in the address units of the current mode
  function automatic step_t seq_step(input req_t q, input logic bm, input logic [5:0] n,
                                     input logic [15:0] mdat);
    step_t s;
    logic [23:0] u1;
    logic [23:0] u2;
    logic [23:0] sa;
    logic [4:0] idx;
    s = '0;
    u1 = bm ? A_BYTE_UNLOCK1 : A_WORD_UNLOCK1;
    u2 = bm ? A_BYTE_UNLOCK2 : A_WORD_UNLOCK2;
    sa = bm ? {q.addr[23:16], 16'h0000} : {1'b0, q.addr[22:15], 15'h0000};
    idx = n[4:0] - BUF_FIRST_STEP[4:0];
    if (n == 6'h00 || n == 6'h03) begin
      s.addr = u1;
      s.data = {8'h00, OP_UNLOCK1};
    end else if (n == 6'h01 || n == 6'h04) begin
      s.addr = u2;
      s.data = {8'h00, OP_UNLOCK2};
    end
    case (q.cmd)
      C_READ: begin
        s = '0;
        s.addr = q.addr;
        s.rd = 1'b1;
        s.last = 1'b1;
      end
      C_RESET: begin
        s = '0;
        s.data = {8'h00, OP_RESET};
        s.last = 1'b1;
      end
      C_IDENT: begin
        if (n == 6'h02) begin
          s.addr = u1;
          s.data = {8'h00, OP_IDENT};
        end else if (n == 6'h03) begin
          s.addr = q.addr;
          s.data = '0;
          s.rd = 1'b1;
          s.last = 1'b1;
        end
      end
      C_SEC_ENTER: begin
        if (n == 6'h02) begin
          s.addr = u1;
          s.data = {8'h00, OP_SECURE};
          s.last = 1'b1;
        end
      end
      C_SEC_EXIT: begin
        if (n == 6'h02) begin
          s.addr = u1;
          s.data = {8'h00, OP_IDENT};
        end else if (n == 6'h03) begin
          s.addr = '0;
          s.data = {8'h00, OP_EXIT};
          s.last = 1'b1;
        end
      end
      C_PROGRAM: begin
        if (n == 6'h02) begin
          s.addr = u1;
          s.data = {8'h00, OP_PROGRAM};
        end else if (n == 6'h03) begin
          s.addr = q.addr;
          s.data = q.data;
          s.last = 1'b1;
        end
      end
      C_BUF_LOAD: begin
        if (n == 6'h02) begin
          s.addr = sa;
          s.data = {8'h00, OP_BUF_LOAD};
        end else if (n == 6'h03) begin
          s.addr = sa;
          s.data = {11'h000, q.count};
        end else if (n >= BUF_FIRST_STEP) begin
          s.addr = bm ? {q.addr[23:5], idx} : {q.addr[23:4], idx[3:0]};
          s.data = mdat;
          s.last = (idx == q.count);
        end
      end
      C_BUF_COMMIT: begin
        s.addr = sa;
        s.data = {8'h00, OP_BUF_COMMIT};
        s.last = 1'b1;
      end
      C_BUF_ABORT: begin
        if (n == 6'h02) begin
          s.addr = u1;
          s.data = {8'h00, OP_RESET};
          s.last = 1'b1;
        end
      end
      C_BYP_ENTER: begin
        if (n == 6'h02) begin
          s.addr = u1;
          s.data = {8'h00, OP_BYPASS};
          s.last = 1'b1;
        end
      end
      C_BYP_PROG: begin
        s = '0;
        if (n == 6'h00) begin
          s.data = {8'h00, OP_PROGRAM};
        end else begin
          s.addr = q.addr;
          s.data = q.data;
          s.last = 1'b1;
        end
      end
      C_BYP_EXIT: begin
        s = '0;
        s.data = (n == 6'h00) ? {8'h00, OP_IDENT} : {8'h00, OP_EXIT};
        s.last = (n != 6'h00);
      end
      C_CHIP_ERASE, C_SECT_ERASE: begin
        if (n == 6'h02) begin
          s.addr = u1;
          s.data = {8'h00, OP_ERASE_SETUP};
        end else if (n == 6'h05) begin
          s.addr = (q.cmd == C_CHIP_ERASE) ? u1 : sa;
          s.data = (q.cmd == C_CHIP_ERASE) ? {8'h00, OP_CHIP_ERASE} : {8'h00, OP_SECTOR_ERASE};
          s.last = 1'b1;
        end
      end
      C_SUSPEND: begin
        s.addr = sa;
        s.data = {8'h00, OP_SUSPEND};
        s.last = 1'b1;
      end
      C_RESUME: begin
        s.addr = sa;
        s.data = {8'h00, OP_RESUME};
        s.last = 1'b1;
      end
      C_QUERY: begin
        s.addr = bm ? A_BYTE_QUERY : A_WORD_QUERY;
        s.data = {8'h00, OP_QUERY};
        s.last = 1'b1;
      end
      default: begin
        s = '0;
        s.last = 1'b1;
      end
    endcase
    if (bm) begin
      s.data = {8'h00, s.data[7:0]};
    end
    return s;
  endfunction

  assign mem_raddr = AW'(r_reg.step - BUF_FIRST_STEP);
  assign cur = seq_step(r_reg.req, r_reg.bm, r_reg.step, mem_rdata);
  assign tick = (r_reg.div == DIV_LAST);
  assign unl_cmd = !(r_reg.req.cmd inside {C_READ, C_RESET, C_BUF_COMMIT, C_BYP_PROG,
                                            C_BYP_EXIT, C_SUSPEND, C_RESUME, C_QUERY});
  assign code_only = !(r_reg.req.cmd inside {C_READ, C_PROGRAM, C_BYP_PROG, C_BUF_LOAD,
                                              C_IDENT});

  flash_buf_mem #(
    .DATA_W(16),
    .DEPTH(BUF_DEPTH),
    .AW(AW)
  ) u_buf (
    .clk_i(CLK_I),
    .we_i(LOAD_WE_I),
    .waddr_i(LOAD_IDX_I),
    .wdata_i(LOAD_DATA_I),
    .raddr_i(mem_raddr),
    .rdata_o(mem_rdata)
  );

  // commands that the tracked device mode does not allow, and word-mode buffer loads with a count past WORD_COUNT_MAX
  always_comb begin
    reject = 1'b0;
    if (r_reg.mode.bypass && !(CMD_I.cmd inside {C_BYP_PROG, C_BYP_EXIT, C_READ})) begin
      reject = 1'b1;
    end
    if (!r_reg.mode.bypass && (CMD_I.cmd inside {C_BYP_PROG, C_BYP_EXIT})) begin
      reject = 1'b1;
    end
    if (CMD_I.cmd == C_SUSPEND && !r_reg.mode.erasing) begin
      reject = 1'b1;
    end
    if (CMD_I.cmd == C_RESUME && !r_reg.mode.suspended) begin
      reject = 1'b1;
    end
    if (CMD_I.cmd == C_QUERY && (r_reg.mode.erasing || r_reg.mode.suspended)) begin
      reject = 1'b1;
    end
    if (CMD_I.cmd == C_BUF_LOAD && !BYTE_MODE_I && CMD_I.count > WORD_COUNT_MAX) begin
      reject = 1'b1;
    end
    if (r_reg.mode.erasing && !(CMD_I.cmd inside {C_SUSPEND, C_READ, C_RESET})) begin
      reject = 1'b1;
    end
  end

  // sequencer
  always_comb begin
    r_next = r_reg;
    r_next.done = 1'b0;
    r_next.refused = 1'b0;
    if (r_reg.st != ST_IDLE) begin
      r_next.div = tick ? '0 : r_reg.div + 1'b1;
    end
    case (r_reg.st)
      ST_IDLE: begin
        if (CMD_VALID_I && r_reg.ready) begin
          if (reject) begin
            r_next.refused = 1'b1;
          end else begin
            r_next.req = CMD_I;
            r_next.bm = BYTE_MODE_I;
            r_next.pins.byte_n = !BYTE_MODE_I;
            r_next.step = '0;
            r_next.div = '0;
            r_next.cnt = SETUP_TICKS;
            r_next.ready = 1'b0;
            r_next.st = ST_SETUP;
          end
        end
      end
      ST_SETUP: begin
        r_next.pins.addr = r_reg.bm ? cur.addr[23:1] : cur.addr[22:0];
        r_next.pins.addr_lsb = r_reg.bm & cur.addr[0];
        r_next.pins.ce_n = 1'b0;
        if (tick) begin
          r_next.cnt = r_reg.cnt - 1'b1;
          if (r_reg.cnt == 4'h1) begin
            r_next.pins.dq = cur.data;
            r_next.pins.dq_oe = !cur.rd;
            r_next.pins.we_n = cur.rd;
            r_next.pins.oe_n = !cur.rd;
            r_next.cnt = cur.rd ? ACCESS_TICKS : WE_LOW_TICKS;
            r_next.st = ST_STROBE;
          end
        end
      end
      ST_STROBE: begin
        if (tick) begin
          r_next.cnt = r_reg.cnt - 1'b1;
          if (r_reg.cnt == 4'h1) begin
            if (cur.rd) begin
              r_next.rdata = r_reg.bm ? {8'h00, DQ_I[7:0]} : DQ_I;
            end
            r_next.pins.we_n = 1'b1;
            r_next.pins.oe_n = 1'b1;
            r_next.cnt = HOLD_TICKS;
            r_next.st = ST_HOLD;
          end
        end
      end
      ST_HOLD: begin
        if (tick) begin
          r_next.cnt = r_reg.cnt - 1'b1;
          if (r_reg.cnt == 4'h1) begin
            r_next.pins.dq_oe = 1'b0;
            r_next.cnt = SETUP_TICKS;
            if (cur.last) begin
              r_next.st = ST_FINISH;
            end else begin
              r_next.step = r_reg.step + 1'b1;
              r_next.st = ST_SETUP;
            end
          end
        end
      end
      ST_FINISH: begin
        r_next.pins.ce_n = 1'b1;
        r_next.done = 1'b1;
        r_next.ready = 1'b1;
        r_next.st = ST_IDLE;
        case (r_reg.req.cmd)
          C_IDENT: r_next.mode.ident = 1'b1;
          C_RESET: begin
            r_next.mode.ident = 1'b0;
            r_next.mode.erasing = 1'b0;
          end
          C_SEC_ENTER: r_next.mode.secure = 1'b1;
          C_SEC_EXIT: r_next.mode.secure = 1'b0;
          C_BYP_ENTER: r_next.mode.bypass = 1'b1;
          C_BYP_EXIT: r_next.mode.bypass = 1'b0;
          C_SECT_ERASE: r_next.mode.erasing = 1'b1;
          C_SUSPEND: begin
            r_next.mode.erasing = 1'b0;
            r_next.mode.suspended = 1'b1;
          end
          C_RESUME: begin
            r_next.mode.suspended = 1'b0;
            r_next.mode.erasing = 1'b1;
          end
          default: r_next.mode = r_reg.mode;
        endcase
      end
      default: r_next.st = ST_IDLE;
    endcase
  end

  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      r_reg <= '0;
      r_reg.st <= ST_IDLE;
      r_reg.pins.ce_n <= 1'b1;
      r_reg.pins.we_n <= 1'b1;
      r_reg.pins.oe_n <= 1'b1;
      r_reg.pins.byte_n <= 1'b1;
      r_reg.ready <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  assign CMD_READY_O = r_reg.ready;
  assign DONE_O = r_reg.done;
  assign REFUSED_O = r_reg.refused;
  assign RDATA_O = r_reg.rdata;
  assign MODE_O = r_reg.mode;
  assign FLASH_O = r_reg.pins;

  // checks
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (!RSTN_I);

  property p_unlock_word;
    (r_reg.st == ST_STROBE && unl_cmd && !r_reg.bm && r_reg.step == 6'h01)
      |-> (r_reg.pins.addr == 23'h00_02AA && r_reg.pins.dq[7:0] == 8'h55 && !r_reg.pins.we_n);
  endproperty
  a_unlock_word: assert property (p_unlock_word) else $error("word unlock step wrong");

  property p_unlock_byte;
    (r_reg.st == ST_STROBE && unl_cmd && r_reg.bm && r_reg.step == 6'h00)
      |-> ({r_reg.pins.addr, r_reg.pins.addr_lsb} == 24'h00_0AAA && r_reg.pins.dq[7:0] == 8'hAA);
  endproperty
  a_unlock_byte: assert property (p_unlock_byte) else $error("byte unlock step wrong");

  property p_hold_stable;
    (r_reg.st == ST_HOLD) |-> ($stable(r_reg.pins.addr) && $stable(r_reg.pins.dq));
  endproperty
  a_hold_stable: assert property (p_hold_stable) else $error("pins moved after strobe");

  property p_code_upper;
    (r_reg.st == ST_STROBE && code_only) |-> (r_reg.pins.dq[15:8] == 8'h00);
  endproperty
  a_code_upper: assert property (p_code_upper) else $error("upper data byte driven");

  property p_sector_only;
    (r_reg.st == ST_STROBE && r_reg.req.cmd == C_SECT_ERASE && !r_reg.bm && r_reg.step == 6'h05)
      |-> (r_reg.pins.addr[14:0] == 15'h0000 && r_reg.pins.dq[7:0] == 8'h30);
  endproperty
  a_sector_only: assert property (p_sector_only) else $error("sector address malformed");

  property p_buf_page;
    (r_reg.st == ST_STROBE && r_reg.req.cmd == C_BUF_LOAD && !r_reg.bm && r_reg.step >= 6'h04)
      |-> (r_reg.pins.addr[22:4] == r_reg.req.addr[22:4]);
  endproperty
  a_buf_page: assert property (p_buf_page) else $error("buffer location off page");

  property p_buf_len;
    (r_reg.req.cmd == C_BUF_LOAD && !r_reg.bm && r_reg.st != ST_IDLE)
      |-> (r_reg.step <= BUF_LAST_STEP_WORD);
  endproperty
  a_buf_len: assert property (p_buf_len) else $error("buffer sequence too long");

  property p_suspend_gate;
    (r_reg.st == ST_IDLE && r_reg.ready && CMD_VALID_I && CMD_I.cmd == C_SUSPEND
      && !r_reg.mode.erasing) |=> (r_reg.refused && r_reg.st == ST_IDLE);
  endproperty
  a_suspend_gate: assert property (p_suspend_gate) else $error("suspend not refused");

  property p_resume_gate;
    (r_reg.st == ST_IDLE && r_reg.ready && CMD_VALID_I && CMD_I.cmd == C_RESUME
      && !r_reg.mode.suspended) |=> r_reg.refused;
  endproperty
  a_resume_gate: assert property (p_resume_gate) else $error("resume not refused");

  property p_bypass_len;
    (r_reg.st == ST_FINISH && r_reg.req.cmd == C_BYP_PROG) |-> (r_reg.step == 6'h01);
  endproperty
  a_bypass_len: assert property (p_bypass_len) else $error("fast program length wrong");

  property p_erase_len;
    (r_reg.st == ST_FINISH && (r_reg.req.cmd inside {C_CHIP_ERASE, C_SECT_ERASE}))
      |-> (r_reg.step == 6'h05) ##1 r_reg.done;
  endproperty
  a_erase_len: assert property (p_erase_len) else $error("erase length wrong");

  property p_program_len;
    (r_reg.st == ST_FINISH && r_reg.req.cmd == C_PROGRAM) |-> (r_reg.step == 6'h03);
  endproperty
  a_program_len: assert property (p_program_len) else $error("program length wrong");

endmodule // flash_host_ctrl
`default_nettype wire

// ---- testbench/flash_dev_model.sv ----
// flash_dev_model: behavioural flash device answering the host pins
// assumes pins registered on the clock; logs each write cycle for the bench
`timescale 1ns/1ps
`default_nettype none
module flash_dev_model
  import flash_host_pkg::*;
#(
  parameter logic [15:0] MAKER_ID = 16'h00C3, // arbitrary value
  parameter logic [15:0] DEV_ID = 16'h3C50, // arbitrary value
  parameter logic [7:0] PROT_SECT = 8'h13
) (
  // clock and pins
  input wire logic clk_i,
  input wire pin_t pins_i,
  output var logic [15:0] dq_o = 16'h0000
);
  logic [39:0] log_q[$];
  logic [39:0] h1_reg = '0, h2_reg = '0;
  logic [23:0] a, a_reg = '0;
  logic [15:0] v;
  logic we_reg = 1'b1, id_reg = 1'b0;
  assign a = pins_i.byte_n ? {1'b0, pins_i.addr} : {pins_i.addr, pins_i.addr_lsb};
  always_comb begin
    if (!id_reg) v = a[15:0] ^ 16'h5A5A;
    else case (a[7:0])
      8'h00: v = MAKER_ID;
      8'h02: v = {15'h0000, a[22:15] == PROT_SECT};
      8'h03: v = 16'h0018;
      default: v = DEV_ID ^ {8'h00, a[7:0]};
    endcase
  end
  // released bus changes every cycle
  always @(posedge clk_i) begin
    dq_o <= (!pins_i.ce_n && !pins_i.oe_n) ? v : ~dq_o;
    we_reg <= pins_i.we_n;
    if (we_reg && !pins_i.we_n) a_reg <= a;
    if (!we_reg && pins_i.we_n && !pins_i.ce_n) begin
      log_q.push_back({a_reg, pins_i.dq});
      h1_reg <= {a_reg, pins_i.dq};
      h2_reg <= h1_reg;
      if (pins_i.dq[7:0] inside {8'hF0, 8'h00}) id_reg <= 1'b0;
      if (pins_i.dq[7:0] == 8'h90 && h1_reg[7:0] == 8'h55 && h2_reg[7:0] == 8'hAA)
        id_reg <= 1'b1;
    end
  end
endmodule // flash_dev_model
`default_nettype wire

// ---- testbench/tb.sv ----
// tb: self-checking bench for the flash host controller
// assumes the package and device model are compiled first
`timescale 1ns/1ps
`default_nettype none
module tb;
  import flash_host_pkg::*;
  typedef struct packed {
    logic rf;
    logic rc;
    logic [15:0] rd;
    mode_t md;
    logic [4:0] mk;
  } note_t;
  localparam logic [15:0] MAKER = 16'h00C3; // arbitrary value
  localparam logic [15:0] DEVC = 16'h3C50; // arbitrary value
  logic clk = 1'b0, rstn = 1'b0, vld = 1'b0, bm = 1'b0, bmp = 1'b0, lwe = 1'b0, rdy, done, refd;
  logic [4:0] lidx = 5'h00;
  logic [15:0] ldat = 16'h0000, dq, rdata, d;
  logic [23:0] a, sa;
  req_t req = '0;
  mode_t em = '0, mode;
  pin_t pins;
  note_t nq[$];
  logic [39:0] wq[$];
  logic [15:0] bufd[16];
  logic [23:0] ia[7] = '{24'h00_0000, 24'h00_0001, 24'h00_000E, 24'h00_000F, 24'h00_0003,
    24'h09_8002, 24'h00_8002};
  logic [15:0] iv[7] = '{MAKER, DEVC ^ 16'h0001, DEVC ^ 16'h000E, DEVC ^ 16'h000F, 16'h0018,
    16'h0001, 16'h0000};
  int n_mismatch = 0, comparisons = 0;
  always #2 clk = ~clk;
  flash_host_ctrl flash_host_ctrl_i (.CLK_I(clk), .RSTN_I(rstn), .CMD_VALID_I(vld), .CMD_I(req),
    .BYTE_MODE_I(bmp), .CMD_READY_O(rdy), .LOAD_WE_I(lwe), .LOAD_IDX_I(lidx), .LOAD_DATA_I(ldat),
    .DONE_O(done), .REFUSED_O(refd), .RDATA_O(rdata), .MODE_O(mode), .FLASH_O(pins), .DQ_I(dq));
  flash_dev_model #(.MAKER_ID(MAKER), .DEV_ID(DEVC)) flash_dev_model_i (.clk_i(clk),
    .pins_i(pins), .dq_o(dq));
  task automatic finish_test();
    $display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string s, input logic [39:0] e, input logic [39:0] g);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic w(input logic [23:0] wa, input logic [15:0] wd);
    wq.push_back({wa, wd});
  endtask
  task automatic ul();
    w(bm ? 24'h00_0AAA : 24'h00_0555, 16'h00AA);
    w(bm ? 24'h00_0555 : 24'h00_02AA, 16'h0055);
  endtask
  task automatic u3(input logic [7:0] op);
    ul();
    w(bm ? 24'h00_0AAA : 24'h00_0555, {8'h00, op});
  endtask
  // one request; expected writes already queued by the caller
  task automatic run(input cmd_t c, input logic [23:0] ra = 24'h00_0000,
      input logic [15:0] rdat = 16'h0000, input logic rf = 1'b0, input logic [4:0] k = 5'h00,
      input logic rc = 1'b0, input logic [15:0] rd = 16'h0000, input logic [4:0] mk = 5'h1F);
    int t;
    nq.push_back('{rf, rc, rd, em, mk});
    if (rf) wq.delete();
    @(posedge clk);
    req <= '{c, ra, rdat, k};
    bmp <= bm;
    vld <= 1'b1;
    @(posedge clk);
    vld <= 1'b0;
    #1;
    for (t = 0; t < 4000 && rdy !== 1'b1; t++) begin
      @(posedge clk);
      #1;
    end
    if (t == 4000) n_mismatch++;
    chk("write count", 40'(wq.size()), 40'(flash_dev_model_i.log_q.size()));
    while (wq.size() > 0 && flash_dev_model_i.log_q.size() > 0)
      chk("write", wq.pop_front(), flash_dev_model_i.log_q.pop_front());
    wq.delete();
    flash_dev_model_i.log_q.delete();
  endtask
  always @(posedge clk) begin
    if (done === 1'b1 || refd === 1'b1) begin
      note_t n;
      n = nq.pop_front();
      chk("refused", 40'(n.rf), 40'(refd));
      chk("mode", 40'(n.md & n.mk), 40'(mode & n.mk));
      if (n.rc) chk("rdata", 40'(n.rd), 40'(rdata));
    end
  end
  initial begin
    #200000;
    n_mismatch++;
    finish_test();
  end
  initial begin
    void'($urandom(32'h6402e863));
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    for (int i = 0; i < 16; i++) begin
      @(posedge clk);
      bufd[i] = 16'($urandom);
      lwe <= 1'b1;
      lidx <= 5'(i);
      ldat <= bufd[i];
    end
    @(posedge clk);
    lwe <= 1'b0;
    a = {1'b0, 23'($urandom)};
    d = 16'($urandom);
    sa = a & 24'h7F_8000;
    run(C_READ, a, 16'h0000, 1'b0, 5'h00, 1'b1, a[15:0] ^ 16'h5A5A);
    run(C_SUSPEND, sa, 16'h0000, 1'b1);
    run(C_RESUME, sa, 16'h0000, 1'b1);
    for (int i = 0; i < 7; i++) begin
      u3(8'h90);
      em.ident = 1'b1;
      run(C_IDENT, ia[i], 16'h0000, 1'b0, 5'h00, 1'b1, iv[i]);
    end
    for (int i = 0; i < 2; i++) begin
      w(24'h00_0000, 16'h00F0);
      em.ident = 1'b0;
      run(C_RESET);
      w(bm ? 24'h00_00AA : 24'h00_0055, 16'h0098);
      run(C_QUERY);
      bm = 1'b1;
      u3(8'h90);
      em.ident = 1'b1;
      run(C_IDENT, 24'h00_0000, 16'h0000, 1'b0, 5'h00, 1'b1, MAKER & 16'h00FF);
    end
    w(24'h00_0000, 16'h00F0);
    em.ident = 1'b0;
    run(C_RESET);
    bm = 1'b0;
    u3(8'h88);
    em.secure = 1'b1;
    run(C_SEC_ENTER);
    u3(8'h90);
    w(24'h00_0000, 16'h0000);
    em.secure = 1'b0;
    run(C_SEC_EXIT, 24'h00_0000, 16'h0000, 1'b0, 5'h00, 1'b0, 16'h0000, 5'h0F);
    u3(8'hA0);
    w(a, d);
    run(C_PROGRAM, a, d);
    u3(8'h25);
    wq[2] = {sa, 16'h0025};
    w(sa, 16'h000F);
    for (int i = 0; i < 16; i++) w(sa | 24'(i), bufd[i]);
    run(C_BUF_LOAD, sa, 16'h0000, 1'b0, 5'h0F);
    w(sa, 16'h0029);
    run(C_BUF_COMMIT, sa);
    run(C_BUF_LOAD, sa, 16'h0000, 1'b1, 5'h10);
    u3(8'hF0);
    run(C_BUF_ABORT);
    u3(8'h20);
    em.bypass = 1'b1;
    run(C_BYP_ENTER);
    run(C_PROGRAM, a, d, 1'b1);
    w(24'h00_0000, 16'h00A0);
    w(a, ~d);
    run(C_BYP_PROG, a, ~d);
    w(24'h00_0000, 16'h0090);
    w(24'h00_0000, 16'h0000);
    em.bypass = 1'b0;
    run(C_BYP_EXIT);
    run(C_BYP_PROG, a, d, 1'b1);
    u3(8'h80);
    u3(8'h10);
    run(C_CHIP_ERASE);
    run(C_SUSPEND, sa, 16'h0000, 1'b1);
    w(24'h00_0000, 16'h00F0);
    em.erasing = 1'b0;
    run(C_RESET);
    u3(8'h80);
    u3(8'h30);
    wq[5] = {sa, 16'h0030};
    em.erasing = 1'b1;
    run(C_SECT_ERASE, sa);
    run(C_QUERY, 24'h00_0000, 16'h0000, 1'b1);
    w(sa, 16'h00B0);
    em.suspended = 1'b1;
    run(C_SUSPEND, sa, 16'h0000, 1'b0, 5'h00, 1'b0, 16'h0000, 5'h1D);
    w(sa, 16'h0030);
    em.suspended = 1'b0;
    run(C_RESUME, sa);
    run(C_RESUME, sa, 16'h0000, 1'b1);
    w(24'h00_0000, 16'h00F0);
    em.erasing = 1'b0;
    run(C_RESET);
    finish_test();
  end
endmodule // tb
`default_nettype wire
